// File: verilog/pd_term_pkg.sv
package pd_term_pkg;
   // ---------------------------------------------------------------
   // timing and mode register bit positions
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int MODE_UPDATE_DELAY_NS = 12;
   localparam int MODE_UPDATE_CYC =
      (MODE_UPDATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CKE_MIN_CYC = 3;
   localparam int FREQ_CHANGE_WAIT_CYC = 2;
   localparam int DLL_RELOCK_CYC = 200;
   localparam int PD_ENTRY_TERM_MARGIN_CYC = 3;
   localparam int PD_EXIT_TERM_MARGIN_CYC = 8;
   localparam int SYNC_TERM_DELAY_CYC = 2;
   localparam int ASYNC_TERM_DELAY_CYC = 1;
   localparam int RESET_CLOCK_STOP_DELAY_CYC = 4;
   localparam int DLL_RESET_BIT = 8;
   localparam int WR_LSB = 9;
   localparam int PD_EXIT_MODE_BIT = 12;
   localparam int TERM_VAL_HI_BIT = 6;
   localparam int TERM_VAL_LO_BIT = 2;
   // ---------------------------------------------------------------
   // commands {cs_n, ras_n, cas_n, we_n}
   // ---------------------------------------------------------------
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_DESEL = 4'hF;
   localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [1:0] BANK_MAIN = 2'h0;
   localparam logic [1:0] BANK_EXT = 2'h1;
endpackage : pd_term_pkg

// File: verilog/sdram_link_if.sv
interface sdram_link_if;
   logic mem_clk;
   logic cke;
   logic termination_enable;
   logic [3:0] cmd;
   logic [1:0] bank;
   logic [13:0] addr;
   logic read_data_valid;
   modport ctrl (output mem_clk, cke, termination_enable, cmd, bank, addr,
      input read_data_valid);
   modport mem (input mem_clk, cke, termination_enable, cmd, bank, addr,
      output read_data_valid);
endinterface : sdram_link_if

// File: verilog/sdram_pd_mem.sv
module sdram_pd_mem
   import pd_term_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   sdram_link_if.mem link,
   output logic in_reset_out,
   output logic initialized_out,
   output logic powered_down_out,
   output logic term_active_out,
   output logic term_async_out,
   output logic dll_locked_out,
   output logic [1:0] termination_value_out,
   output logic [2:0] wr_setting_out
);
   typedef enum {M_RESET, M_ACTIVE, M_PD} mstate_e;
   mstate_e state;
   logic [1:0] clk_sync, cke_sync, term_sync;
   logic clk_prev, cke_q, term_q, rise;
   logic [13:0] main_mode_reg, extended_mode_reg;
   logic [7:0] relock_cnt, since_change, since_exit;
   logic [1:0] apply_cnt;
   logic burst_pend, read_seen, pd_armed;
   // ---------------------------------------------------------------
   // pin sampling, link clock edges
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         clk_sync <= 2'h0;
         cke_sync <= 2'h0;
         term_sync <= 2'h0;
         clk_prev <= 1'b0;
      end else begin
         clk_sync <= {clk_sync[0], link.mem_clk};
         cke_sync <= {cke_sync[0], link.cke};
         term_sync <= {term_sync[0], link.termination_enable};
         clk_prev <= clk_sync[1];
      end
   end
   assign rise = clk_sync[1] & ~clk_prev;
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= M_RESET;
         cke_q <= 1'b0;
         initialized_out <= 1'b0;
         main_mode_reg <= 14'h0000;
         extended_mode_reg <= 14'h0000;
         relock_cnt <= 8'h00;
         burst_pend <= 1'b0;
         read_seen <= 1'b0;
         pd_armed <= 1'b0;
         since_exit <= 8'hFF;
      end else if (rise) begin
         cke_q <= cke_sync[1];
         if (relock_cnt != 8'h00)
            relock_cnt <= relock_cnt - 8'h01;
         if (since_exit != 8'hFF)
            since_exit <= since_exit + 8'h01;
         unique case (state)
            M_RESET: begin
               // only cke is looked at here
               if (cke_sync[1]) begin
                  state <= M_ACTIVE;
                  burst_pend <= read_seen;
                  read_seen <= 1'b0;
               end
            end
            M_ACTIVE: begin
               burst_pend <= 1'b0;
               if (!cke_sync[1]) begin
                  // only a drop after a precharge is power-down entry;
                  // any other drop, or one mid-burst, is the reset
                  if (!initialized_out || !pd_armed ||
                      link.cmd == CMD_READ) begin
                     state <= M_RESET;
                     initialized_out <= 1'b0;
                     read_seen <= link.cmd == CMD_READ;
                  end else
                     state <= M_PD;
               end else if (link.cmd == CMD_PRECHARGE) begin
                  pd_armed <= 1'b1;
               end else if (link.cmd == CMD_MODE_LOAD) begin
                  initialized_out <= 1'b1;
                  if (link.bank == BANK_MAIN) begin
                     main_mode_reg <= link.addr;
                     if (link.addr[DLL_RESET_BIT])
                        relock_cnt <= 8'(DLL_RELOCK_CYC);
                  end else if (link.bank == BANK_EXT)
                     extended_mode_reg <= link.addr;
               end
            end
            M_PD: begin
               if (cke_sync[1]) begin
                  state <= M_ACTIVE;
                  since_exit <= 8'h00;
                  // next power-down entry needs a fresh precharge
                  pd_armed <= 1'b0;
               end
            end
            default: state <= M_RESET;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // termination timing category
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         term_q <= 1'b0;
         since_change <= 8'hFF;
         term_async_out <= 1'b0;
         apply_cnt <= 2'h0;
         term_active_out <= 1'b0;
      end else if (rise) begin
         term_q <= term_sync[1];
         if (since_change != 8'hFF)
            since_change <= since_change + 8'h01;
         if (term_sync[1] != term_q) begin
            since_change <= 8'h00;
            // cke high: synchronous, unless inside exit margin
            if (cke_sync[1])
               term_async_out <= since_exit < 8'(PD_EXIT_TERM_MARGIN_CYC)
                  && since_exit != 8'hFF;
            else
               // precharged: always async; active: async on slow exit
               term_async_out <= pd_armed ||
                  main_mode_reg[PD_EXIT_MODE_BIT];
            apply_cnt <= cke_sync[1] ? 2'(SYNC_TERM_DELAY_CYC) :
               2'(ASYNC_TERM_DELAY_CYC);
         end else if (apply_cnt != 2'h0) begin
            apply_cnt <= apply_cnt - 2'h1;
            if (apply_cnt == 2'h1)
               term_active_out <= term_q && state != M_RESET;
         end
         // late change before entry falls to async timing
         if (state == M_ACTIVE && !cke_sync[1] &&
             since_change < 8'(PD_ENTRY_TERM_MARGIN_CYC))
            term_async_out <= 1'b1;
         if (state == M_RESET)
            term_active_out <= 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         in_reset_out <= 1'b1;
         powered_down_out <= 1'b0;
         dll_locked_out <= 1'b0;
         termination_value_out <= 2'h0;
         wr_setting_out <= 3'h0;
         link.read_data_valid <= 1'b0;
      end else begin
         in_reset_out <= state == M_RESET;
         powered_down_out <= state == M_PD;
         dll_locked_out <= relock_cnt == 8'h00 && initialized_out;
         termination_value_out <= {extended_mode_reg[TERM_VAL_HI_BIT],
            extended_mode_reg[TERM_VAL_LO_BIT]};
         wr_setting_out <= main_mode_reg[WR_LSB +: 3];
         link.read_data_valid <= burst_pend;
      end
   end
endmodule : sdram_pd_mem

// File: verilog/sdram_pd_ctrl.sv
module sdram_pd_ctrl
   import pd_term_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   sdram_link_if.ctrl link,
   input wire logic freq_change_req_in,
   input wire logic slow_clk_in,
   input wire logic reset_req_in,
   input wire logic [2:0] new_wr_in,
   output logic busy_out,
   output logic burst_seen_out
);
   typedef enum {C_INIT, C_IDLE, C_PD, C_FREQ, C_EXIT, C_DLL, C_RELOCK,
      C_RST_WAIT, C_RST_STOP} cstate_e;
   cstate_e state;
   logic [7:0] cnt;
   logic [2:0] div;
   logic slow, slow_phase;
   logic [1:0] rd_sync;
   // link clock toggles every 8 clk_in, or every 16 when slow
   wire logic tick = div == 3'h7 && (!slow || slow_phase);
   wire logic update = tick && !link.mem_clk && state != C_RST_STOP;
   // ---------------------------------------------------------------
   // link clock divider, /16 or /32
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         div <= 3'h0;
         slow_phase <= 1'b0;
         link.mem_clk <= 1'b0;
         rd_sync <= 2'h0;
      end else begin
         rd_sync <= {rd_sync[0], link.read_data_valid};
         div <= div + 3'h1;
         if (div == 3'h7)
            slow_phase <= ~slow_phase;
         // clock held still while stopped for reset
         if (tick && state != C_RST_STOP)
            link.mem_clk <= ~link.mem_clk;
      end
   end
   // ---------------------------------------------------------------
   // sequencer, counts in link-clock rising edges, or every 8 clk_in while the clock is stopped
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= C_INIT;
         cnt <= 8'h00;
         slow <= 1'b0;
         link.cke <= 1'b0;
         link.termination_enable <= 1'b0;
         link.cmd <= CMD_NOP;
         link.bank <= BANK_MAIN;
         link.addr <= 14'h0000;
         busy_out <= 1'b1;
         burst_seen_out <= 1'b0;
      end else begin
         if (rd_sync[1])
            burst_seen_out <= 1'b1;
         if (update) begin
            cnt <= cnt + 8'h01;
            link.cmd <= CMD_NOP;
            unique case (state)
               C_INIT: begin
                  link.cke <= 1'b1;
                  if (cnt == 8'(CKE_MIN_CYC)) begin
                     link.cmd <= CMD_MODE_LOAD;
                     link.bank <= BANK_MAIN;
                     link.addr <= 14'h0000 | (14'(new_wr_in) << WR_LSB);
                     state <= C_IDLE;
                     cnt <= 8'h00;
                  end
               end
               C_IDLE: begin
                  busy_out <= 1'b0;
                  if (reset_req_in) begin
                     link.cke <= 1'b0;
                     link.termination_enable <= 1'b0;
                     state <= C_RST_WAIT;
                     busy_out <= 1'b1;
                     cnt <= 8'h00;
                  end else if (freq_change_req_in &&
                               cnt >= 8'(MODE_UPDATE_CYC + CKE_MIN_CYC)) begin
                     link.cmd <= CMD_PRECHARGE;
                     link.termination_enable <= 1'b0;
                     state <= C_PD;
                     busy_out <= 1'b1;
                     cnt <= 8'h00;
                  end
               end
               C_PD: begin
                  // enter precharge power-down once precharged
                  if (cnt == 8'(PD_ENTRY_TERM_MARGIN_CYC)) begin
                     link.cke <= 1'b0;
                     cnt <= 8'h00;
                     state <= C_FREQ;
                  end
               end
               C_FREQ: begin
                  if (cnt == 8'(FREQ_CHANGE_WAIT_CYC))
                     slow <= slow_clk_in;
                  if (cnt == 8'(FREQ_CHANGE_WAIT_CYC + CKE_MIN_CYC)) begin
                     link.cke <= 1'b1;
                     cnt <= 8'h00;
                     state <= C_EXIT;
                  end
               end
               C_EXIT: begin
                  if (cnt == 8'(CKE_MIN_CYC)) begin
                     link.cmd <= CMD_MODE_LOAD;
                     link.bank <= BANK_MAIN;
                     link.addr <= (14'h0001 << DLL_RESET_BIT) |
                        (14'(new_wr_in) << WR_LSB);
                     cnt <= 8'h00;
                     state <= C_RELOCK;
                  end
               end
               C_RELOCK: begin
                  link.termination_enable <= 1'b0;
                  if (cnt == 8'(DLL_RELOCK_CYC)) begin
                     link.cmd <= CMD_MODE_LOAD;
                     link.bank <= BANK_EXT;
                     link.addr <= 14'h0001 << TERM_VAL_LO_BIT;
                     cnt <= 8'h00;
                     state <= C_DLL;
                  end
               end
               C_DLL: begin
                  // termination stays low until the mode delay passes
                  if (cnt == 8'(MODE_UPDATE_CYC)) begin
                     link.termination_enable <= 1'b1;
                     state <= C_IDLE;
                     cnt <= 8'h00;
                  end
               end
               C_RST_WAIT: begin
                  if (cnt == 8'(RESET_CLOCK_STOP_DELAY_CYC)) begin
                     state <= C_RST_STOP;
                     cnt <= 8'h00;
                  end
               end
               default: state <= C_INIT;
            endcase
         end
         // stopped clock: restart after a fixed wait, then reinitialize
         if (state == C_RST_STOP && div == 3'h7) begin
            cnt <= cnt + 8'h01;
            if (cnt == 8'(RESET_CLOCK_STOP_DELAY_CYC)) begin
               state <= C_INIT;
               cnt <= 8'h00;
            end
         end
      end
   end
endmodule : sdram_pd_ctrl

// File: bench/sdram_pd_monitor.sv
module sdram_pd_monitor
   import pd_term_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic mem_clk,
   input wire logic cke,
   input wire logic termination_enable,
   input wire logic [3:0] cmd,
   input wire logic [1:0] bank,
   input wire logic [13:0] addr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic cke_q;
   logic [7:0] cke_age;
   logic [15:0] relock_age;
   wire logic main_load = cmd == CMD_MODE_LOAD && bank == BANK_MAIN;
   wire logic ext_load = cmd == CMD_MODE_LOAD && bank == BANK_EXT;
   // ---------------------------------------------------------------
   // ages in clk_in cycles since the last cke edge and dll reset
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cke_q <= 1'b0;
         cke_age <= 8'hFF;
      end else begin
         cke_q <= cke;
         if (cke != cke_q) begin
            cke_age <= 8'h00;
         end else if (cke_age != 8'hFF) begin
            cke_age <= cke_age + 8'h01;
         end
      end
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         relock_age <= 16'hFFFF;
      end else if (main_load && addr[DLL_RESET_BIT]) begin
         relock_age <= 16'h0000;
      end else if (relock_age != 16'hFFFF) begin
         relock_age <= relock_age + 16'h0001;
      end
   end
   default clocking mon_cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   sequence cke_drop;
      $fell(cke);
   endsequence
   sequence two_link_rises;
      ##[1:40] $rose(mem_clk) ##[1:40] $rose(mem_clk);
   endsequence
   sequence ext_load_seq;
      ext_load;
   endsequence
   // three link cycles are 48 clk_in cycles at the fastest rate
   chk_cke_hold_min: assert property (
      cke != cke_q |-> cke_age >= 8'h2F)
      else $error("cke level held under three link cycles");
   chk_pd_term_off: assert property (
      !cke |-> !termination_enable)
      else $error("termination on while cke low");
   chk_pd_cmd_nop: assert property (
      !cke |-> cmd == CMD_NOP || cmd == CMD_DESEL)
      else $error("command other than nop while cke low");
   chk_exit_mode_load: assert property (
      $rose(cke) |-> ##[1:200] main_load)
      else $error("no main mode load after cke rise");
   // relock window at the fastest link rate
   chk_relock_term_off: assert property (
      relock_age < 16'h0C80 |-> !termination_enable)
      else $error("termination on during dll relock");
   chk_ext_load_term: assert property (
      ext_load_seq |-> !termination_enable ##1 !termination_enable [*8])
      else $error("termination on inside mode update window");
   chk_term_off_before: assert property (
      $rose(ext_load) |-> !$past(termination_enable, 32))
      else $error("termination not off before value update");
   chk_clk_after_drop: assert property (
      cke_drop |-> two_link_rises)
      else $error("link clock stopped too soon after cke drop");
   chk_link_clk_even: assert property (
      $changed(mem_clk) |=> $stable(mem_clk) [*7])
      else $error("link clock half period too short");
endmodule : sdram_pd_monitor

// File: bench/sdram_powerdown_odt_reset_ctrl_bench.sv
module sdram_powerdown_odt_reset_ctrl_bench
   import pd_term_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in, rst_in, freq_change_req, slow_clk, reset_req, seen_reset;
   logic [2:0] new_wr, wr_setting;
   logic [1:0] term_value;
   logic busy, burst_seen, in_reset, initialized, powered_down;
   logic term_active, term_async, dll_locked;
   int err_total = 0;
   int comparisons = 0;
   int seed = 32'h96d3;
   int exp_wr_q[$];
   int exp_period, n, w;
   sdram_link_if sdram_link_if_i ();
   sdram_pd_ctrl sdram_pd_ctrl_i (.clk_in(clk_in), .rst_in(rst_in),
      .link(sdram_link_if_i), .freq_change_req_in(freq_change_req),
      .slow_clk_in(slow_clk), .reset_req_in(reset_req), .new_wr_in(new_wr),
      .busy_out(busy), .burst_seen_out(burst_seen));
   sdram_pd_mem sdram_pd_mem_i (.clk_in(clk_in), .rst_in(rst_in),
      .link(sdram_link_if_i), .in_reset_out(in_reset),
      .initialized_out(initialized), .powered_down_out(powered_down),
      .term_active_out(term_active), .term_async_out(term_async),
      .dll_locked_out(dll_locked), .termination_value_out(term_value),
      .wr_setting_out(wr_setting));
   sdram_pd_monitor sdram_pd_monitor_i (.clk_in(clk_in), .rst_in(rst_in),
      .mem_clk(sdram_link_if_i.mem_clk), .cke(sdram_link_if_i.cke),
      .termination_enable(sdram_link_if_i.termination_enable),
      .cmd(sdram_link_if_i.cmd), .bank(sdram_link_if_i.bank),
      .addr(sdram_link_if_i.addr));
   // ---------------------------------------------------------------
   // clock, watchdog and shared tasks
   // ---------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      #2400000;
      err_total++;
      give_verdict();
   end
   always @(posedge clk_in) begin
      if (in_reset === 1'b1 && rst_in === 1'b0) begin
         seen_reset <= 1'b1;
      end
   end
   task automatic give_verdict();
      if (err_total == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : check
   task automatic wait_busy(input logic lvl);
      int k;
      k = 0;
      while (busy !== lvl && k < 20000) begin
         @(posedge clk_in);
         k++;
      end
      check(busy === lvl, "busy wait ran out");
   endtask : wait_busy
   // period of the link clock in clk_in cycles
   task automatic link_period(output int cyc);
      time t0;
      @(posedge sdram_link_if_i.mem_clk);
      t0 = $time;
      @(posedge sdram_link_if_i.mem_clk);
      cyc = int'(($time - t0) / 40);
   endtask : link_period
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      rst_in = 1'b1;
      freq_change_req = 1'b0;
      slow_clk = 1'b0;
      reset_req = 1'b0;
      new_wr = 3'h0;
      seen_reset = 1'b0;
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      wait_busy(1'b0);
      check(initialized === 1'b1 && in_reset === 1'b0, "not initialized");
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_in);
         w = $random(seed);
         exp_wr_q.push_back(w & 7);
         exp_period = i[0] ? 16 : 32;
         new_wr <= w[2:0];
         slow_clk <= ~i[0];
         freq_change_req <= 1'b1;
         wait_busy(1'b1);
         freq_change_req <= 1'b0;
         wait_busy(1'b0);
         check(wr_setting === 3'(exp_wr_q.pop_front()), "write recovery");
         check(dll_locked === 1'b1 && powered_down === 1'b0, "not locked");
         link_period(n);
         link_period(n);
         check(n === exp_period, "link clock period");
         check(term_active === 1'b1 && term_async === 1'b0, "sync term");
         check(term_value === 2'h1, "termination value");
      end
      @(posedge clk_in);
      seen_reset <= 1'b0;
      reset_req <= 1'b1;
      wait_busy(1'b1);
      reset_req <= 1'b0;
      wait_busy(1'b0);
      check(seen_reset === 1'b1, "reset condition not entered");
      check(initialized === 1'b1 && in_reset === 1'b0, "no reinit");
      check(term_active === 1'b0, "termination kept after reset");
      check(burst_seen === 1'b0, "burst finished with no read");
      @(posedge clk_in);
      rst_in <= 1'b1;
      @(posedge clk_in);
      rst_in <= 1'b0;
      wait_busy(1'b0);
      check(initialized === 1'b1, "no init after second reset");
      give_verdict();
   end
endmodule : sdram_powerdown_odt_reset_ctrl_bench
